// file: hw/dsp_baud.sv
// Purpose: Auto-baud detector and generator period source
// Assumes: Host opens with character 0x80, eight low bit times
// Notes:   Stays idle after reset or clear until the pin idles high first
`timescale 1ns/1ps
`default_nettype none
module dsp_baud
  import dsp_pkg::*;
(
  input  wire logic CORE_CLK,
  input  wire logic RSTN,
  dsp_baud_if.baud  bi
);

  dsp_baud_e         st_q,  st_d;
  logic [MEAS_W-1:0] cnt_q, cnt_d;
  logic [PER_W-1:0]  per_q, per_d;
  logic [PER_W-1:0]  meas_per;

  assign meas_per  = cnt_q[MEAS_W-1:AUTOBAUD_SHIFT];
  assign bi.period = per_q;
  assign bi.locked = (st_q == B_LOCK);

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    per_d = per_q;
    case (st_q)
      // A low pin at release is not a start bit; wait for idle first
      B_WAIT_HIGH: if (bi.pin) st_d = B_WAIT_FALL;
      B_WAIT_FALL: begin
        cnt_d = '0;
        // The falling-edge sample is already the first low cycle of the run
        if (!bi.pin) begin
          st_d  = B_MEAS;
          cnt_d = 16'h0001;
        end
      end
      B_MEAS: begin
        if (!bi.pin) begin
          if (cnt_q != MEAS_MAX) cnt_d = cnt_q + 16'h0001;
        end else if (meas_per >= MIN_PERIOD) begin
          per_d = meas_per;
          st_d  = B_LOCK;
        end else begin
          st_d = B_WAIT_FALL;
        end
      end
      B_LOCK:  st_d = B_LOCK;
      default: st_d = B_WAIT_HIGH;
    endcase
    if (bi.clr) st_d = B_WAIT_HIGH;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      st_q  <= B_WAIT_HIGH;
      cnt_q <= '0;
      per_q <= MIN_PERIOD;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      per_q <= per_d;
    end
  end

  property p_lock_period;
    @(posedge CORE_CLK) disable iff (!RSTN)
    $rose(bi.locked) |-> (bi.period >= MIN_PERIOD) && $past(bi.pin);
  endproperty
  a_lock_period: assert property (p_lock_period) else $error("Locked on a short period");

  property p_period_held;
    @(posedge CORE_CLK) disable iff (!RSTN)
    bi.locked && $past(bi.locked) |-> $stable(bi.period);
  endproperty
  a_period_held: assert property (p_period_held) else $error("Period moved while locked");

endmodule // dsp_baud
`default_nettype wire

// file: hw/dsp_baud_if.sv
// Purpose: Carrier between the link logic and the baud detector
// Assumes: Both ends run on the core clock
// Notes:   Period is valid only while locked is high
`timescale 1ns/1ps
`default_nettype none
interface dsp_baud_if;
  import dsp_pkg::*;
  logic             pin;
  logic             clr;
  logic [PER_W-1:0] period;
  logic             locked;

  modport baud (input pin, input clr, output period, output locked);
  modport user (output pin, output clr, input period, input locked);
endinterface
`default_nettype wire

// file: hw/dsp_pkg.sv
// Purpose: Shared constants and types of the debug serial port
// Assumes: One core clock; the debug pin is already synchronous to it
// Notes:   Bit period is learned from the first character, not configured
package dsp_pkg;

  // Measurement counter and derived bit period widths
  localparam int unsigned MEAS_W = 16;
  localparam int unsigned PER_W  = 13;
  // The first character is 0x80: start plus seven zero bits, eight low bits
  localparam int unsigned AUTOBAUD_SHIFT = 3;
  // Shortest period accepted, in core clocks per bit
  localparam logic [PER_W-1:0] MIN_PERIOD = 13'h0004;
  localparam logic [MEAS_W-1:0] MEAS_MAX = 16'hFFFF;

  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  localparam logic [3:0] TX_FRAME_BITS = 4'hA;

  // Reset values
  localparam logic       MODE_RST   = 1'b0;
  localparam logic [9:0] TX_SH_IDLE = 10'h3FF;

  typedef enum logic [1:0] {
    B_WAIT_HIGH = 2'b00,
    B_WAIT_FALL = 2'b01,
    B_MEAS      = 2'b10,
    B_LOCK      = 2'b11
  } dsp_baud_e;

  typedef enum logic [1:0] {
    R_IDLE  = 2'b00,
    R_START = 2'b01,
    R_DATA  = 2'b10,
    R_STOP  = 2'b11
  } dsp_rx_e;

endpackage

// file: hw/dsp_top.sv
// Purpose: One-wire debug serial link with auto-baud and debug mode state
// Assumes: All inputs synchronous to CORE_CLK; the host releases the pin
// Notes:   Half duplex; reception is ignored while the device transmits
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module dsp_top
  import dsp_pkg::*;
(
  input  wire logic       CORE_CLK,
  input  wire logic       RSTN,
  input  wire logic       DBG_PIN_I,
  output var  logic       DBG_PIN_O,
  output var  logic       DBG_PIN_OE,
  input  wire logic       RST_POR,
  input  wire logic       RST_BOR,
  input  wire logic       RST_WDT,
  input  wire logic       EXT_RESET_N,
  input  wire logic       STOP_MODE,
  input  wire logic       MODE_WR,
  input  wire logic       MODE_WDATA,
  output var  logic       DEBUG_MODE,
  output var  logic       SYS_RESET_REQ,
  output var  logic [7:0] RX_DATA,
  output var  logic       RX_VALID,
  input  wire logic [7:0] TX_DATA,
  input  wire logic       TX_VALID,
  output var  logic       TX_READY
);

  dsp_baud_if bif ();

  dsp_baud u_baud (
    .CORE_CLK (CORE_CLK),
    .RSTN     (RSTN),
    .bi       (bif.baud)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Debug mode and reset-driven exits

  logic mode_q, mode_d;
  logic srst_q, srst_d;
  logic stop_rst;
  logic leave_rst;
  logic lock_q;

  assign stop_rst  = STOP_MODE && !DBG_PIN_I;
  assign leave_rst = RST_POR || RST_BOR || RST_WDT || !EXT_RESET_N || stop_rst;
  assign bif.pin   = DBG_PIN_I;
  // Any reset source drops the learned rate so the link idles again
  assign bif.clr   = leave_rst;

  always_comb begin
    srst_d = stop_rst;
    mode_d = mode_q;
    if (bif.locked && !lock_q) mode_d = 1'b1;
    if (MODE_WR) mode_d = MODE_WDATA;
    if (RST_POR || RST_BOR || RST_WDT) mode_d = 1'b0;
    if (!EXT_RESET_N) mode_d = 1'b0;
    if (stop_rst) mode_d = 1'b0;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      mode_q <= MODE_RST;
      srst_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      srst_q <= srst_d;
      lock_q <= bif.locked;
    end
  end

  assign DEBUG_MODE    = mode_q;
  assign SYS_RESET_REQ = srst_q;

  ////////////////////////////////////////////////////////////////////////////
  // Receiver

  dsp_rx_e          rx_st_q,  rx_st_d;
  logic [PER_W-1:0] rx_cnt_q, rx_cnt_d;
  logic [2:0]       rx_bit_q, rx_bit_d;
  logic [7:0]       rx_sh_q,  rx_sh_d;
  logic             rx_vld_q, rx_vld_d;
  logic             pin_prev_q;
  logic             tx_take;
  logic             tx_busy_q, tx_busy_d;

  always_comb begin
    rx_st_d  = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d  = rx_sh_q;
    rx_vld_d = 1'b0;
    if (rx_cnt_q != '0) rx_cnt_d = rx_cnt_q - 13'h0001;
    case (rx_st_q)
      R_IDLE: begin
        // Own transmission echoes on the pin, so never start under it
        if (bif.locked && pin_prev_q && !DBG_PIN_I && !tx_busy_q && !tx_take) begin
          rx_st_d  = R_START;
          rx_cnt_d = {1'b0, bif.period[PER_W-1:1]};
        end
      end
      R_START: begin
        if (rx_cnt_q == '0) begin
          rx_cnt_d = bif.period - 13'h0001;
          rx_bit_d = '0;
          // A glitch shorter than half a bit is not a start bit
          rx_st_d  = DBG_PIN_I ? R_IDLE : R_DATA;
        end
      end
      R_DATA: begin
        if (rx_cnt_q == '0) begin
          rx_sh_d  = {DBG_PIN_I, rx_sh_q[7:1]};
          rx_cnt_d = bif.period - 13'h0001;
          rx_bit_d = rx_bit_q + 3'h1;
          if (rx_bit_q == LAST_DATA_BIT) rx_st_d = R_STOP;
        end
      end
      R_STOP: begin
        if (rx_cnt_q == '0) begin
          rx_vld_d = DBG_PIN_I;
          rx_st_d  = R_IDLE;
        end
      end
      default: rx_st_d = R_IDLE;
    endcase
    // A stop sample landing as the rate is dropped must not leak a byte
    if (!bif.locked) begin
      rx_st_d  = R_IDLE;
      rx_vld_d = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      rx_st_q    <= R_IDLE;
      rx_cnt_q   <= '0;
      rx_bit_q   <= '0;
      rx_sh_q    <= '0;
      rx_vld_q   <= 1'b0;
      pin_prev_q <= 1'b1;
    end else begin
      rx_st_q    <= rx_st_d;
      rx_cnt_q   <= rx_cnt_d;
      rx_bit_q   <= rx_bit_d;
      rx_sh_q    <= rx_sh_d;
      rx_vld_q   <= rx_vld_d;
      pin_prev_q <= DBG_PIN_I;
    end
  end

  assign RX_DATA  = rx_sh_q;
  assign RX_VALID = rx_vld_q;

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter

  logic [9:0]       tx_sh_q,  tx_sh_d;
  logic [PER_W-1:0] tx_cnt_q, tx_cnt_d;
  logic [3:0]       tx_bit_q, tx_bit_d;
  logic             tx_rdy_q, tx_rdy_d;

  // Taking a byte in the cycle RX_VALID pulses, one after the stop sample, gives the zero-gap reply
  assign tx_take = TX_VALID && TX_READY;

  always_comb begin
    tx_sh_d   = tx_sh_q;
    tx_cnt_d  = tx_cnt_q;
    tx_bit_d  = tx_bit_q;
    tx_busy_d = tx_busy_q;
    if (tx_take) begin
      tx_sh_d   = {1'b1, TX_DATA, 1'b0};
      tx_cnt_d  = bif.period - 13'h0001;
      tx_bit_d  = '0;
      tx_busy_d = 1'b1;
    end else if (tx_busy_q) begin
      if (tx_cnt_q != '0) begin
        tx_cnt_d = tx_cnt_q - 13'h0001;
      end else if (tx_bit_q == TX_FRAME_BITS - 4'h1) begin
        tx_busy_d = 1'b0;
        tx_sh_d   = TX_SH_IDLE;
      end else begin
        tx_sh_d  = {1'b1, tx_sh_q[9:1]};
        tx_cnt_d = bif.period - 13'h0001;
        tx_bit_d = tx_bit_q + 4'h1;
      end
    end
    if (!bif.locked) begin
      tx_busy_d = 1'b0;
      tx_sh_d   = TX_SH_IDLE;
    end
    // Ready only while idle on both directions and rate known
    tx_rdy_d = bif.locked && !bif.clr && !tx_busy_d && (rx_st_d == R_IDLE);
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      tx_sh_q   <= TX_SH_IDLE;
      tx_cnt_q  <= '0;
      tx_bit_q  <= '0;
      tx_busy_q <= 1'b0;
      tx_rdy_q  <= 1'b0;
    end else begin
      tx_sh_q   <= tx_sh_d;
      tx_cnt_q  <= tx_cnt_d;
      tx_bit_q  <= tx_bit_d;
      tx_busy_q <= tx_busy_d;
      tx_rdy_q  <= tx_rdy_d;
    end
  end

  assign DBG_PIN_O  = tx_sh_q[0];
  assign DBG_PIN_OE = tx_busy_q;
  assign TX_READY   = tx_rdy_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Start bit is low from its first cycle and still low, with the driver on, one cycle later
  sequence s_tx_start;
    !DBG_PIN_O ##1 (DBG_PIN_OE && !DBG_PIN_O);
  endsequence

  property p_mode_clr;
    @(posedge CORE_CLK) disable iff (!RSTN)
    MODE_WR && !MODE_WDATA |=> !DEBUG_MODE;
  endproperty
  a_mode_clr: assert property (p_mode_clr) else $error("Mode kept after clear");

  property p_rst_exit;
    @(posedge CORE_CLK) disable iff (!RSTN)
    RST_POR || RST_BOR || RST_WDT |=> !DEBUG_MODE && !TX_READY;
  endproperty
  a_rst_exit: assert property (p_rst_exit) else $error("Mode kept after reset");

  property p_pin_exit;
    @(posedge CORE_CLK) disable iff (!RSTN)
    !EXT_RESET_N |=> !DEBUG_MODE;
  endproperty
  a_pin_exit: assert property (p_pin_exit) else $error("Mode kept under reset pin");

  property p_stop_rst;
    @(posedge CORE_CLK) disable iff (!RSTN)
    STOP_MODE && !DBG_PIN_I |=> SYS_RESET_REQ && !DEBUG_MODE;
  endproperty
  a_stop_rst: assert property (p_stop_rst) else $error("No reset from stop wake");

  property p_tx_frame;
    @(posedge CORE_CLK) disable iff (!RSTN)
    $rose(DBG_PIN_OE) |-> $past(tx_take) ##0 s_tx_start;
  endproperty
  a_tx_frame: assert property (p_tx_frame) else $error("Bad start bit");

  property p_tx_stop;
    @(posedge CORE_CLK) disable iff (!RSTN)
    $fell(DBG_PIN_OE) && bif.locked |-> $past(DBG_PIN_O);
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("Stop bit not high");

  property p_reply;
    @(posedge CORE_CLK) disable iff (!RSTN)
    tx_take && bif.locked |=> DBG_PIN_OE && !DBG_PIN_O;
  endproperty
  a_reply: assert property (p_reply) else $error("Reply not started");

  property p_idle;
    @(posedge CORE_CLK) disable iff (!RSTN)
    !bif.locked && !$past(bif.locked) |-> !DBG_PIN_OE && !RX_VALID && !TX_READY;
  endproperty
  a_idle: assert property (p_idle) else $error("Active before baud lock");

  property p_stop_chk;
    @(posedge CORE_CLK) disable iff (!RSTN)
    RX_VALID |-> $past(DBG_PIN_I) && $past(rx_st_q == R_STOP);
  endproperty
  a_stop_chk: assert property (p_stop_chk) else $error("Byte kept with low stop");

endmodule // dsp_top
`default_nettype wire

// file: verification/dsp_host_model.sv
// Purpose: Debug host adapter on the one-wire pin
// Assumes: The pin has a pull-up; bit period given in core clocks
// Notes:   Open-drain only, so it can never collide with a reply
`timescale 1ns/1ps
`default_nettype none
module dsp_host_model (
  input  wire logic CORE_CLK,
  input  wire logic pin,
  output var  logic host_low
);
  initial host_low = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // A high stop bit is released, never driven high, so a reply may start mid-stop
  task automatic send_char(input logic [7:0] d, input int per, input logic stop_hi);
    logic [9:0] f;
    f = {stop_hi, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      host_low = ~f[i];
      repeat (per) @(posedge CORE_CLK);
      #1;
    end
    host_low = 1'b0;
  endtask
  task automatic pull(input logic v);
    host_low = v;
  endtask
  // Samples each bit near its middle with the same period as sent
  task automatic recv_char(input int per, output logic [9:0] f);
    int n;
    n = 0;
    while (pin !== 1'b0 && n < 4 * per) begin
      @(posedge CORE_CLK);
      #1;
      n++;
    end
    repeat (per / 2) @(posedge CORE_CLK);
    #1;
    for (int i = 0; i < 10; i++) begin
      f[i] = pin;
      repeat (per) @(posedge CORE_CLK);
      #1;
    end
  endtask
endmodule // dsp_host_model
`default_nettype wire

// file: verification/dsp_tb_top.sv
// Purpose: Self-checking bench of the debug serial port
// Assumes: Host model on the far side, pin pulled up when released
// Notes:   Bit period of 16 clocks leaves margin around the mid-stop reply
`timescale 1ns/1ps
`default_nettype none
module dsp_tb_top;
  localparam int P = 16;
  logic       core_clk, rstn, rst_por, rst_bor, rst_wdt, ext_reset_n;
  logic       stop_mode, mode_wr, mode_wdata, tx_valid, host_low;
  logic       pin_o, pin_oe, debug_mode, sys_reset_req, rx_valid, tx_ready;
  logic [7:0] tx_data, rx_data;
  wire  logic dbg_pin;
  int         errors = 0;
  int         check_count = 0;
  int         cycles = 0;
  int         rx_pulses = 0;
  int         mark;
  int         per = P;
  logic [15:0] rows [4] = '{16'h005A, 16'hFF01, 16'hA580, 16'h3CFE};

  assign dbg_pin = pin_oe ? pin_o : ~host_low;

  dsp_top uut (
    .CORE_CLK      (core_clk),
    .RSTN          (rstn),
    .DBG_PIN_I     (dbg_pin),
    .DBG_PIN_O     (pin_o),
    .DBG_PIN_OE    (pin_oe),
    .RST_POR       (rst_por),
    .RST_BOR       (rst_bor),
    .RST_WDT       (rst_wdt),
    .EXT_RESET_N   (ext_reset_n),
    .STOP_MODE     (stop_mode),
    .MODE_WR       (mode_wr),
    .MODE_WDATA    (mode_wdata),
    .DEBUG_MODE    (debug_mode),
    .SYS_RESET_REQ (sys_reset_req),
    .RX_DATA       (rx_data),
    .RX_VALID      (rx_valid),
    .TX_DATA       (tx_data),
    .TX_VALID      (tx_valid),
    .TX_READY      (tx_ready)
  );
  dsp_host_model host (.CORE_CLK(core_clk), .pin(dbg_pin), .host_low(host_low));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic end_sim;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (rx_valid === 1'b1) rx_pulses++;
    if (cycles == 40000) begin
      errors++;
      end_sim();
    end
  end

  task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic autobaud;
    host.send_char(8'h80, per, 1'b1);
    tick(2);
    chk("mode_lock", 10'(debug_mode), 10'h001);
  endtask

  // Host sends a byte; the reply is offered as soon as it arrives
  task automatic xfer(input logic [7:0] rb, input logic [7:0] tb);
    int n;
    logic done;
    logic [9:0] fr;
    done = 1'b0;
    fork
      begin
        host.send_char(rb, per, 1'b1);
        done = 1'b1;
      end
      begin
        n = 0;
        while (rx_valid !== 1'b1 && n < 12 * per) begin
          tick(1);
          n++;
        end
        chk("rx_valid", 10'(rx_valid), 10'h001);
        chk("rx_data", 10'(rx_data), 10'(rb));
        tx_data = tb;
        tx_valid = 1'b1;
        n = 0;
        while (tx_ready !== 1'b1 && n < 4 * per) begin
          tick(1);
          n++;
        end
        tick(1);
        tx_valid = 1'b0;
        chk("reply_gap", 10'(done), 10'h000);
        host.recv_char(per, fr);
        chk("tx_frame", fr, {1'b1, tb, 1'b0});
      end
    join
  endtask

  task automatic src(input int k);
    rst_por = (k == 0);
    rst_bor = (k == 1);
    rst_wdt = (k == 2);
    ext_reset_n = (k != 3);
    rstn = (k != 4);
    tick(2);
    {rst_por, rst_bor, rst_wdt, ext_reset_n, rstn} = 5'h03;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_por, rst_bor, rst_wdt, stop_mode, mode_wr, mode_wdata, tx_valid} = 7'h00;
    ext_reset_n = 1'b1;
    tx_data = 8'hC3;
    rstn = 1'b0;
    tick(16);
    rstn = 1'b1;
    // A byte offered before any character must not go out
    tx_valid = 1'b1;
    for (int i = 0; i < 20; i++) begin
      tick(1);
      chk("idle_oe", 10'(pin_oe), 10'h000);
      chk("idle_ready", 10'(tx_ready), 10'h000);
    end
    chk("idle_mode", 10'(debug_mode), 10'h000);
    tx_valid = 1'b0;
    autobaud();
    for (int i = 0; i < 4; i++) xfer(rows[i][15:8], rows[i][7:0]);
    // Low stop bit, then a good character must still get through
    mark = rx_pulses;
    host.send_char(8'h55, P, 1'b0);
    tick(P);
    chk("drop", 10'(rx_pulses - mark), 10'h000);
    xfer(8'h96, 8'h69);
    mode_wr = 1'b1;
    mode_wdata = 1'b0;
    tick(1);
    chk("mode_clr", 10'(debug_mode), 10'h000);
    mode_wdata = 1'b1;
    tick(1);
    chk("mode_set", 10'(debug_mode), 10'h001);
    mode_wr = 1'b0;
    for (int k = 0; k < 5; k++) begin
      src(k);
      tick(3);
      chk("mode_src", 10'(debug_mode), 10'h000);
      chk("ready_src", 10'(tx_ready), 10'h000);
      autobaud();
    end
    stop_mode = 1'b1;
    tick(2);
    chk("wake_idle", 10'(sys_reset_req), 10'h000);
    host.pull(1'b1);
    tick(2);
    chk("wake", 10'(sys_reset_req), 10'h001);
    tick(2);
    chk("mode_wake", 10'(debug_mode), 10'h000);
    host.pull(1'b0);
    stop_mode = 1'b0;
    tick(2);
    chk("wake_end", 10'(sys_reset_req), 10'h000);
    // Second bit rate: relock at half the period, then a full transfer
    per = P / 2;
    autobaud();
    xfer(8'hC5, 8'h3A);
    end_sim();
  end
endmodule // dsp_tb_top
`default_nettype wire
